// [rtl/rtc_regs.vh]
// register offsets, field positions, reset values and timing constants
// assumes inclusion by the time-keeping core and its step module
//
// What this block does
// (R01) threshold select: 0 picks 2.1 V (default), 1 picks 1.6 V
// (R02) supply below threshold sets low-supply flag; held, monitor disabled
// (R03) writing 0 clears low-supply flag, restarts monitor; writing 1 ignored
// (R04) oscillator halt sets halt flag; stays set after oscillation resumes
// (R05) halt flag setting clears adjust, control one and all other status bits
// (R06) writing 0 clears halt flag and rearms sensing; writing 1 ignored
// (R07) spare bits D5, D3 store written values; cleared on halt flag
// (R08) periodic flag reads 1 while line A periodic output is low
// (R09) level mode: writing 0 releases line A until next period
// (R10) enabled alarm match sets alarm flag about 61 us later
// (R11) writing 0 clears alarm flag, releases line; weekly B, daily A
// (R12) alarm flag reads 0 while its enable bit is 0
// (R13) seconds, minutes count BCD 00..59, carry on wrap
// (R14) hours carry to day counters on PM11->AM12 or 23->00
// (R15) any seconds write resets the sub-second divider
// (R16) weekday counter steps 000..110 then wraps to 000
// (R17) host must not write 111 to weekday unless unused
// (R18) host writes only valid time values to the counters
// (R19) host should poll the halt flag often
// (R20) hour mode 0: 12-hour, bit 5 is PM; mode 1: 00..23
// (R21) unused bits ignore writes and read as 0
`ifndef RTC_REGS_VH
`define RTC_REGS_VH

// offsets
`define OFS_SECONDS      4'h0
`define OFS_MINUTES      4'h1
`define OFS_HOURS        4'h2
`define OFS_WEEKDAY      4'h3
`define OFS_OSC_ADJUST   4'h7
`define OFS_CTRL_ONE     4'hE
`define OFS_STATUS       4'hF

// status register fields
`define ST_THRESH_SEL    7
`define ST_LOW_SUPPLY    6
`define ST_SPARE_ONE     5
`define ST_OSC_HALT      4
`define ST_SPARE_TWO     3
`define ST_PERIODIC      2
`define ST_WEEKLY        1
`define ST_DAILY         0
`define ST_RESET         8'h10

// control one fields
`define C1_WEEKLY_EN     7
`define C1_DAILY_EN      6
`define C1_MODE24        5
`define C1_SPARE_THREE   4
`define C1_FACTORY_TEST  3
`define C1_RESET         8'h00

// periodic select codes
`define PER_OFF          3'h0
`define PER_FIXED_LOW    3'h1
`define PER_2HZ          3'h2
`define PER_1HZ          3'h3
`define PER_SEC          3'h4
`define PER_MIN          3'h5
`define PER_HOUR         3'h6
`define PER_MONTH        3'h7

// timing
`define XTAL_HZ          32768
`define DIV_LAST         15'h7FFF
`define ALARM_DELAY_US   61
`define WEEKDAY_LAST     3'h6

`endif

// [rtl/rtc_time_step.v]
// one-second step of the BCD time counters
// assumes valid BCD values at its inputs
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.vh"

module rtc_time_step (
   // present time
   input  wire [6:0] sec_in,
   input  wire [6:0] min_in,
   input  wire [5:0] hour_in,
   input  wire [2:0] wday_in,
   input  wire       mode24,
   // next time and carries
   output reg  [6:0] sec_out,
   output reg  [6:0] min_out,
   output reg  [5:0] hour_out,
   output reg  [2:0] wday_out,
   output reg        min_carry,
   output reg        hour_carry,
   output reg        day_carry
);

   function [7:0] bcd_inc;
      input [7:0] v;
      begin
         if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
         end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
         end
      end
   endfunction

   reg [7:0] tmp;

   always @* begin
      tmp        = 8'h00;
      min_carry  = (sec_in == 7'h59);
      hour_carry = min_carry && (min_in == 7'h59);
      day_carry  = 1'b0;
      // seconds and minutes
      if (min_carry) begin // see (R13)
         sec_out = 7'h00;
      end else begin
         tmp     = bcd_inc({1'b0, sec_in});
         sec_out = tmp[6:0];
      end
      if (!min_carry) begin
         min_out = min_in;
      end else if (hour_carry) begin // see (R13)
         min_out = 7'h00;
      end else begin
         tmp     = bcd_inc({1'b0, min_in});
         min_out = tmp[6:0];
      end
      // hours
      hour_out = hour_in;
      if (hour_carry) begin
         if (mode24) begin // see (R20)
            if (hour_in == 6'h23) begin
               hour_out  = 6'h00;
               day_carry = 1'b1; // see (R14)
            end else begin
               tmp      = bcd_inc({2'b00, hour_in});
               hour_out = tmp[5:0];
            end
         end else if (hour_in[4:0] == 5'h12) begin
            hour_out = {hour_in[5], 5'h01};
         end else if (hour_in[4:0] == 5'h11) begin
            hour_out  = {~hour_in[5], 5'h12}; // see (R20)
            day_carry = hour_in[5]; // see (R14)
         end else begin
            tmp      = bcd_inc({3'b000, hour_in[4:0]});
            hour_out = {hour_in[5], tmp[4:0]};
         end
      end
      // weekday
      if (!day_carry) begin
         wday_out = wday_in;
      end else if (wday_in == `WEEKDAY_LAST) begin // see (R16)
         wday_out = 3'h0;
      end else begin
         wday_out = wday_in + 3'h1;
      end
   end

endmodule

`default_nettype wire

// [rtl/rtc_core.v]
// status flags, control registers and time-of-day counters
// assumes a decoded serial-bus register port and a crystal tick
// pulse, all synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.vh"

module rtc_core #(
   parameter XTAL_HZ = `XTAL_HZ
) (
   // clock and reset
   input  wire       mclk,
   input  wire       sys_rst,
   // decoded register port
   input  wire [3:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata_ff,
   // crystal and analog monitors
   input  wire       xtal_tick,
   input  wire       xtal_level,
   input  wire       osc_running,
   input  wire       supply_below_2v1,
   input  wire       supply_below_1v6,
   input  wire       clkout_pin_enable,
   // alarm compare and calendar
   input  wire       weekly_alarm_match,
   input  wire       daily_alarm_match,
   input  wire       month_rollover,
   output reg        day_carry_ff,
   // interrupt and clock pins
   output reg        irq_line_a_n,
   output reg        irq_line_b_n,
   output reg        crystal_clock_out
);

   // --------------------------------------------------------------
   // constants
   // --------------------------------------------------------------
   localparam integer ALARM_DELAY_FULL =
      ((`ALARM_DELAY_US * XTAL_HZ + 999999) / 1000000);
   localparam [1:0] ALARM_DELAY_TICKS = ALARM_DELAY_FULL[1:0];

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   reg [6:0]  seconds_count_ff;
   reg [6:0]  minutes_count_ff;
   reg [5:0]  hours_count_ff;
   reg [2:0]  weekday_count_ff;
   reg [6:0]  osc_adjust_ff;
   reg [7:0]  ctrl_one_ff;
   reg        supply_threshold_select_ff;
   reg        low_supply_flag_ff;
   reg        spare_bit_one_ff;
   reg        spare_bit_two_ff;
   reg        osc_halt_flag_ff;
   reg        halt_armed_ff;
   reg        periodic_pend_ff;
   reg        weekly_alarm_flag_ff;
   reg        daily_alarm_flag_ff;
   reg [14:0] div_ff;
   reg [1:0]  weekly_dly_ff;
   reg [1:0]  daily_dly_ff;

   // --------------------------------------------------------------
   // decode
   // --------------------------------------------------------------
   wire wr_sec    = reg_wr && (reg_addr == `OFS_SECONDS);
   wire wr_min    = reg_wr && (reg_addr == `OFS_MINUTES);
   wire wr_hour   = reg_wr && (reg_addr == `OFS_HOURS);
   wire wr_wday   = reg_wr && (reg_addr == `OFS_WEEKDAY);
   wire wr_adj    = reg_wr && (reg_addr == `OFS_OSC_ADJUST);
   wire wr_ctrl1  = reg_wr && (reg_addr == `OFS_CTRL_ONE);
   wire wr_status = reg_wr && (reg_addr == `OFS_STATUS);

   wire       weekly_en = ctrl_one_ff[`C1_WEEKLY_EN];
   wire       daily_en  = ctrl_one_ff[`C1_DAILY_EN];
   wire       mode24    = ctrl_one_ff[`C1_MODE24];
   wire [2:0] per_sel   = ctrl_one_ff[2:0];

   // --------------------------------------------------------------
   // timebase
   // --------------------------------------------------------------
   wire sec_tick = xtal_tick && (div_ff == `DIV_LAST);

   wire [6:0] nxt_sec;
   wire [6:0] nxt_min;
   wire [5:0] nxt_hour;
   wire [2:0] nxt_wday;
   wire       min_carry;
   wire       hour_carry;
   wire       day_carry;

   rtc_time_step u_step (
      .sec_in     (seconds_count_ff),
      .min_in     (minutes_count_ff),
      .hour_in    (hours_count_ff),
      .wday_in    (weekday_count_ff),
      .mode24     (mode24),
      .sec_out    (nxt_sec),
      .min_out    (nxt_min),
      .hour_out   (nxt_hour),
      .wday_out   (nxt_wday),
      .min_carry  (min_carry),
      .hour_carry (hour_carry),
      .day_carry  (day_carry)
   );

   always @(posedge mclk) begin
      if (sys_rst || wr_sec) begin
         div_ff <= 15'h0000; // see (R15)
      end else if (xtal_tick) begin
         div_ff <= div_ff + 15'h0001;
      end
   end

   // --------------------------------------------------------------
   // time counters
   // --------------------------------------------------------------
   always @(posedge mclk) begin
      if (sys_rst) begin
         seconds_count_ff <= 7'h00;
         minutes_count_ff <= 7'h00;
         hours_count_ff   <= 6'h12;
         weekday_count_ff <= 3'h0;
         day_carry_ff     <= 1'b0;
      end else begin
         day_carry_ff <= sec_tick && day_carry; // see (R14)
         if (wr_sec) begin
            seconds_count_ff <= reg_wdata[6:0]; // see (R21)
         end else if (sec_tick) begin
            seconds_count_ff <= nxt_sec; // see (R13)
         end
         if (wr_min) begin
            minutes_count_ff <= reg_wdata[6:0];
         end else if (sec_tick) begin
            minutes_count_ff <= nxt_min; // see (R13)
         end
         if (wr_hour) begin
            hours_count_ff <= reg_wdata[5:0];
         end else if (sec_tick) begin
            hours_count_ff <= nxt_hour; // see (R20)
         end
         if (wr_wday) begin
            weekday_count_ff <= reg_wdata[2:0];
         end else if (sec_tick) begin
            weekday_count_ff <= nxt_wday; // see (R16)
         end
      end
   end

   // --------------------------------------------------------------
   // oscillator halt sensing
   // --------------------------------------------------------------
   wire halt_event = halt_armed_ff && !osc_running;
   wire halt_clear = wr_status && !reg_wdata[`ST_OSC_HALT];

   always @(posedge mclk) begin
      if (sys_rst) begin
         osc_halt_flag_ff <= 1'b1;
         halt_armed_ff    <= 1'b0;
      end else if (halt_event) begin
         osc_halt_flag_ff <= 1'b1; // see (R04)
         halt_armed_ff    <= 1'b0;
      end else if (halt_clear) begin
         osc_halt_flag_ff <= 1'b0; // see (R06)
         halt_armed_ff    <= 1'b1;
      end
   end

   // --------------------------------------------------------------
   // control one and adjustment
   // --------------------------------------------------------------
   always @(posedge mclk) begin
      if (sys_rst || halt_event) begin
         ctrl_one_ff   <= `C1_RESET; // see (R05)
         osc_adjust_ff <= 7'h00;
      end else begin
         if (wr_ctrl1) begin
            ctrl_one_ff <= reg_wdata;
         end
         if (wr_adj) begin
            osc_adjust_ff <= reg_wdata[6:0]; // see (R21)
         end
      end
   end

   // --------------------------------------------------------------
   // supply monitor
   // --------------------------------------------------------------
   wire below_sel = supply_threshold_select_ff ? supply_below_1v6 // see (R01)
                                               : supply_below_2v1;
   wire supply_event = !low_supply_flag_ff && below_sel;

   always @(posedge mclk) begin
      if (sys_rst || halt_event) begin
         supply_threshold_select_ff <= 1'b0; // see (R01)
         low_supply_flag_ff         <= 1'b0;
         spare_bit_one_ff           <= 1'b0; // see (R07)
         spare_bit_two_ff           <= 1'b0;
      end else begin
         if (wr_status) begin
            supply_threshold_select_ff <= reg_wdata[`ST_THRESH_SEL];
            spare_bit_one_ff <= reg_wdata[`ST_SPARE_ONE]; // see (R07)
            spare_bit_two_ff <= reg_wdata[`ST_SPARE_TWO];
         end
         if (supply_event) begin
            low_supply_flag_ff <= 1'b1; // see (R02)
         end else if (wr_status && !reg_wdata[`ST_LOW_SUPPLY]) begin
            low_supply_flag_ff <= 1'b0; // see (R03)
         end
      end
   end

   // --------------------------------------------------------------
   // periodic interrupt
   // --------------------------------------------------------------
   reg per_event;
   reg per_low;

   always @* begin
      case (per_sel)
         `PER_SEC:   per_event = sec_tick;
         `PER_MIN:   per_event = sec_tick && min_carry;
         `PER_HOUR:  per_event = sec_tick && hour_carry;
         `PER_MONTH: per_event = month_rollover;
         default:    per_event = 1'b0;
      endcase
   end

   always @(posedge mclk) begin
      if (sys_rst || halt_event || !per_sel[2]) begin
         periodic_pend_ff <= 1'b0;
      end else if (per_event) begin
         periodic_pend_ff <= 1'b1;
      end else if (wr_status && !reg_wdata[`ST_PERIODIC]) begin
         periodic_pend_ff <= 1'b0; // see (R09)
      end
   end

   always @* begin
      case (per_sel)
         `PER_OFF:       per_low = 1'b0;
         `PER_FIXED_LOW: per_low = 1'b1;
         `PER_2HZ:       per_low = div_ff[13];
         `PER_1HZ:       per_low = div_ff[14];
         default:        per_low = periodic_pend_ff;
      endcase
   end

   // --------------------------------------------------------------
   // alarm flags
   // --------------------------------------------------------------
   wire weekly_set = weekly_dly_ff == 2'd1 && xtal_tick;
   wire daily_set  = daily_dly_ff == 2'd1 && xtal_tick;

   always @(posedge mclk) begin
      if (sys_rst || halt_event || !weekly_en) begin
         weekly_dly_ff <= 2'd0;
      end else if (weekly_alarm_match && weekly_dly_ff == 2'd0) begin
         weekly_dly_ff <= ALARM_DELAY_TICKS; // see (R10)
      end else if (xtal_tick && weekly_dly_ff != 2'd0) begin
         weekly_dly_ff <= weekly_dly_ff - 2'd1;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst || halt_event || !daily_en) begin
         daily_dly_ff <= 2'd0;
      end else if (daily_alarm_match && daily_dly_ff == 2'd0) begin
         daily_dly_ff <= ALARM_DELAY_TICKS; // see (R10)
      end else if (xtal_tick && daily_dly_ff != 2'd0) begin
         daily_dly_ff <= daily_dly_ff - 2'd1;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst || halt_event || !weekly_en) begin
         weekly_alarm_flag_ff <= 1'b0; // see (R12)
      end else if (weekly_set) begin
         weekly_alarm_flag_ff <= 1'b1; // see (R10)
      end else if (wr_status && !reg_wdata[`ST_WEEKLY]) begin
         weekly_alarm_flag_ff <= 1'b0; // see (R11)
      end
   end

   always @(posedge mclk) begin
      if (sys_rst || halt_event || !daily_en) begin
         daily_alarm_flag_ff <= 1'b0; // see (R12)
      end else if (daily_set) begin
         daily_alarm_flag_ff <= 1'b1; // see (R10)
      end else if (wr_status && !reg_wdata[`ST_DAILY]) begin
         daily_alarm_flag_ff <= 1'b0; // see (R11)
      end
   end

   // --------------------------------------------------------------
   // pins
   // --------------------------------------------------------------
   always @(posedge mclk) begin
      if (sys_rst) begin
         irq_line_a_n      <= 1'b1;
         irq_line_b_n      <= 1'b1;
         crystal_clock_out <= 1'b0;
      end else begin
         irq_line_a_n <= !(per_low || daily_alarm_flag_ff); // see (R11)
         irq_line_b_n <= !weekly_alarm_flag_ff; // see (R11)
         crystal_clock_out <= clkout_pin_enable && xtal_level;
      end
   end

   // --------------------------------------------------------------
   // read mux
   // --------------------------------------------------------------
   reg [7:0] rd_mux;

   always @* begin
      case (reg_addr)
         `OFS_SECONDS:    rd_mux = {1'b0, seconds_count_ff}; // see (R21)
         `OFS_MINUTES:    rd_mux = {1'b0, minutes_count_ff};
         `OFS_HOURS:      rd_mux = {2'b00, hours_count_ff};
         `OFS_WEEKDAY:    rd_mux = {5'h00, weekday_count_ff};
         `OFS_OSC_ADJUST: rd_mux = {1'b0, osc_adjust_ff};
         `OFS_CTRL_ONE:   rd_mux = ctrl_one_ff;
         `OFS_STATUS:     rd_mux = {supply_threshold_select_ff,
                                    low_supply_flag_ff,
                                    spare_bit_one_ff,
                                    osc_halt_flag_ff,
                                    spare_bit_two_ff,
                                    per_low, // see (R08)
                                    weekly_alarm_flag_ff && weekly_en,
                                    daily_alarm_flag_ff && daily_en};
         default:         rd_mux = 8'h00;
      endcase
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata_ff <= rd_mux;
      end
   end

endmodule

`default_nettype wire

// [bench/rtc_host_model.sv]
// host side of the register port: byte writes and reads
// assumes the decoded port of rtc_core, strobes sampled on mclk rising edge
`timescale 1ns/1ps
`default_nettype none

module rtc_host_model (
   // clock
   input  wire logic       mclk,
   // register port
   output var  logic [3:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   output var  logic       reg_wr,
   output var  logic       reg_rd,
   input  wire logic [7:0] reg_rdata_ff
);
   // ------------------------------------------------------------
   // bus cycles
   // ------------------------------------------------------------
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // caller passes valid time values only, weekday never 111
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge mclk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~d;
      reg_addr = ~a;
   endtask

   // status is read back often by the caller
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge mclk);
      #1;
      d = reg_rdata_ff;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask
endmodule

`default_nettype wire

// [bench/rtc_core_checker.sv]
// port-level assertions on rtc_core
// assumes a bind from the bench top, one clock domain on mclk
`timescale 1ns/1ps
`default_nettype none

module rtc_core_checker #(
   parameter XTAL_HZ = 32768
) (
   // clock and reset
   input wire logic       mclk,
   input wire logic       sys_rst,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata_ff,
   // crystal side
   input wire logic       xtal_tick,
   input wire logic       xtal_level,
   input wire logic       clkout_pin_enable,
   // pins
   input wire logic       day_carry_ff,
   input wire logic       irq_line_a_n,
   input wire logic       irq_line_b_n,
   input wire logic       crystal_clock_out
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   property p_unmapped;
      reg_rd && reg_addr == 4'hD |=> reg_rdata_ff == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");

   property p_sec_bcd;
      reg_rd && reg_addr <= 4'h1 |=> !reg_rdata_ff[7] &&
         reg_rdata_ff[6:4] <= 3'h5 && reg_rdata_ff[3:0] <= 4'h9;
   endproperty
   a_sec_bcd: assert property (p_sec_bcd)
      else $error("seconds or minutes out of range");

   property p_hour_top;
      reg_rd && reg_addr == 4'h2 |=> reg_rdata_ff[7:6] == 2'h0;
   endproperty
   a_hour_top: assert property (p_hour_top)
      else $error("hour unused bits set");

   property p_wday;
      reg_rd && reg_addr == 4'h3 |=>
         reg_rdata_ff[7:3] == 5'h00 && reg_rdata_ff[2:0] != 3'h7;
   endproperty
   a_wday: assert property (p_wday)
      else $error("weekday out of range");

   property p_rd_hold;
      !reg_rd |=> $stable(reg_rdata_ff);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved without read");

   property p_clkout;
      !$past(sys_rst) |->
         crystal_clock_out == $past(clkout_pin_enable && xtal_level);
   endproperty
   a_clkout: assert property (p_clkout)
      else $error("clock output not gated level");

   property p_carry_pulse;
      day_carry_ff |=> !day_carry_ff;
   endproperty
   a_carry_pulse: assert property (p_carry_pulse)
      else $error("day carry longer than one cycle");

   property p_wk_line;
      $fell(irq_line_b_n) |->
         $past(xtal_tick) || $past(xtal_tick, 2) || $past(xtal_tick, 3);
   endproperty
   a_wk_line: assert property (p_wk_line)
      else $error("line b fell away from a tick");

   property p_reset_lines;
      disable iff (1'b0)
      sys_rst |=> irq_line_a_n && irq_line_b_n && !day_carry_ff;
   endproperty
   a_reset_lines: assert property (p_reset_lines)
      else $error("lines not released in reset");
endmodule

`default_nettype wire

// [bench/tb_rtc_core.sv]
// self-checking bench for rtc_core
// assumes rtc_host_model for register cycles and the bound checker
`timescale 1ns/1ps
`default_nettype none

module tb_rtc_core;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] r;} row_t;
   logic       mclk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata_ff, got, fl;
   logic       reg_wr, reg_rd, day_carry_ff, crystal_clock_out;
   logic       irq_line_a_n, irq_line_b_n;
   logic       xtal_tick = 1'b0, osc_running = 1'b1, clk_en = 1'b1;
   logic       below_2v1 = 1'b0, below_1v6 = 1'b0, mon_roll = 1'b0;
   logic       wk_match = 1'b0, dy_match = 1'b0;
   int         miscompares = 0, samples_checked = 0, cycles = 0, dc = 0;
   int         i;
   row_t       rows [7] = '{'{4'h0, 8'hD9, 8'h59}, '{4'h1, 8'h80, 8'h00},
      '{4'h2, 8'hE3, 8'h23}, '{4'h3, 8'hF5, 8'h05},
      '{4'h7, 8'hFF, 8'h7F}, '{4'hD, 8'hFF, 8'h00},
      '{4'hE, 8'h10, 8'h10}};

   rtc_core #(.XTAL_HZ(32768)) DUT (.mclk(mclk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .xtal_tick(xtal_tick),
      .xtal_level(xtal_tick), .osc_running(osc_running),
      .supply_below_2v1(below_2v1), .supply_below_1v6(below_1v6),
      .clkout_pin_enable(clk_en), .weekly_alarm_match(wk_match),
      .daily_alarm_match(dy_match), .month_rollover(mon_roll),
      .day_carry_ff(day_carry_ff), .irq_line_a_n(irq_line_a_n),
      .irq_line_b_n(irq_line_b_n), .crystal_clock_out(crystal_clock_out));

   rtc_host_model host (.mclk(mclk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_ff(reg_rdata_ff));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   always #2.5 mclk = ~mclk;

   always @(posedge mclk) begin
      cycles++;
      if (day_carry_ff === 1'b1) dc++;
      if (cycles == 90000) begin
         miscompares++;
         summarize();
      end
   end

   task automatic summarize;
      if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] act, input logic [7:0] exp);
      samples_checked++;
      if (act !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, act, exp);
      end
   endtask

   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      host.rd(a, got);
      chk8(got, e);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic ticks(input int n);
      xtal_tick = 1'b1;
      repeat (n) @(posedge mclk);
      #1 xtal_tick = 1'b0;
   endtask

   task automatic fire(input int k);
      wk_match = (k == 0);
      dy_match = (k == 1);
      cyc(1);
      wk_match = 1'b0;
      dy_match = 1'b0;
      ticks(1);
      rc(4'hF, 8'h28);
      ticks(1);
      cyc(2);
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      cyc(3);
      sys_rst = 1'b0;
      chk8({6'h00, irq_line_a_n, irq_line_b_n}, 8'h03);
      rc(4'hF, 8'h10);
      host.wr(4'hF, 8'h00);
      rc(4'hF, 8'h00);
      for (i = 0; i < 7; i++) begin
         host.wr(rows[i].a, rows[i].w);
         rc(rows[i].a, rows[i].r);
      end
      host.wr(4'hF, 8'hFF);
      rc(4'hF, 8'hA8);
      below_2v1 = 1'b1;
      rc(4'hF, 8'hA8);
      below_1v6 = 1'b1;
      cyc(2);
      below_1v6 = 1'b0;
      below_2v1 = 1'b0;
      rc(4'hF, 8'hE8);
      host.wr(4'hF, 8'h28);
      rc(4'hF, 8'h28);
      below_2v1 = 1'b1;
      rc(4'hF, 8'h68);
      below_2v1 = 1'b0;
      host.wr(4'hF, 8'h28);
      host.wr(4'hE, 8'h07);
      mon_roll = 1'b1;
      cyc(1);
      mon_roll = 1'b0;
      cyc(2);
      chk8({7'h00, irq_line_a_n}, 8'h00);
      rc(4'hF, 8'h2C);
      host.wr(4'hF, 8'h28);
      cyc(2);
      chk8({7'h00, irq_line_a_n}, 8'h01);
      host.wr(4'hE, 8'h01);
      cyc(2);
      chk8({7'h00, irq_line_a_n}, 8'h00);
      rc(4'hF, 8'h2C);
      for (i = 0; i < 2; i++) begin
         fl = (i == 0) ? 8'h02 : 8'h01;
         host.wr(4'hE, (i == 0) ? 8'h80 : 8'h40);
         fire(i);
         rc(4'hF, 8'h28 | fl);
         chk8({7'h00, i == 0 ? irq_line_b_n : irq_line_a_n}, 8'h00);
         host.wr(4'hF, 8'h28);
         cyc(2);
         chk8({7'h00, i == 0 ? irq_line_b_n : irq_line_a_n}, 8'h01);
         fire(i);
         chk8({7'h00, i == 0 ? irq_line_b_n : irq_line_a_n}, 8'h00);
         host.wr(4'hE, 8'h00);
         rc(4'hF, 8'h28);
      end
      host.wr(4'hE, 8'hB1);
      host.wr(4'h7, 8'h55);
      osc_running = 1'b0;
      cyc(2);
      osc_running = 1'b1;
      cyc(2);
      rc(4'hF, 8'h10);
      rc(4'hE, 8'h00);
      rc(4'h7, 8'h00);
      chk8({6'h00, irq_line_a_n, irq_line_b_n}, 8'h03);
      clk_en = 1'b0;
      cyc(2);
      chk8({7'h00, crystal_clock_out}, 8'h00);
      clk_en = 1'b1;
      host.wr(4'hF, 8'h00);
      host.wr(4'hE, 8'h05);
      host.wr(4'h1, 8'h59);
      host.wr(4'h2, 8'h31);
      host.wr(4'h3, 8'h06);
      host.wr(4'h0, 8'h59);
      ticks(32767);
      rc(4'h0, 8'h59);
      ticks(1);
      cyc(2);
      rc(4'h0, 8'h00);
      rc(4'h1, 8'h00);
      rc(4'h2, 8'h12);
      rc(4'h3, 8'h00);
      chk8(8'(dc), 8'h01);
      rc(4'hF, 8'h04);
      chk8({7'h00, irq_line_a_n}, 8'h00);
      host.wr(4'hF, 8'h00);
      host.wr(4'hE, 8'h26);
      chk8({7'h00, irq_line_a_n}, 8'h01);
      host.wr(4'h1, 8'h59);
      host.wr(4'h2, 8'h23);
      host.wr(4'h0, 8'h59);
      ticks(32768);
      cyc(2);
      rc(4'h2, 8'h00);
      rc(4'h3, 8'h01);
      rc(4'hF, 8'h04);
      chk8(8'(dc), 8'h02);
      sys_rst = 1'b1;
      cyc(3);
      sys_rst = 1'b0;
      rc(4'hF, 8'h10);
      summarize();
   end
endmodule

bind rtc_core rtc_core_checker #(.XTAL_HZ(XTAL_HZ)) u_chk (.mclk(mclk),
   .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata_ff(reg_rdata_ff), .xtal_tick(xtal_tick),
   .xtal_level(xtal_level), .clkout_pin_enable(clkout_pin_enable),
   .day_carry_ff(day_carry_ff), .irq_line_a_n(irq_line_a_n),
   .irq_line_b_n(irq_line_b_n), .crystal_clock_out(crystal_clock_out));

`default_nettype wire
